// ---- design/pncs_pkg.sv ----
// Package for the parallel NOR flash command sequencer: commands, query layout, types
package pncs_pkg;

	// Flash data bus width in bits
	localparam int DATA_W = 16;

	// Flash command values
	localparam logic [15:0] CMD_QUERY = 16'h0098;
	localparam logic [15:0] CMD_READ_ARRAY = 16'h00FF;
	localparam logic [15:0] CMD_UNLOCK_SETUP = 16'h0060;
	localparam logic [15:0] CMD_CONFIRM = 16'h00D0;
	localparam logic [15:0] CMD_ERASE_SETUP = 16'h0020;
	localparam logic [15:0] CMD_READ_STATUS = 16'h0070;
	localparam logic [15:0] CMD_CLEAR_STATUS = 16'h0050;
	localparam logic [15:0] CMD_BUF_PROG = 16'h00E8;

	// Query offsets read in order: Q, R, Y, size exponent, block size low, block size high
	localparam int QRY_COUNT = 6;
	localparam logic [47:0] QRY_OFFS = {8'h30, 8'h2F, 8'h27, 8'h12, 8'h11, 8'h10};
	localparam logic [7:0] ASCII_Q = 8'h51;
	localparam logic [7:0] ASCII_R = 8'h52;
	localparam logic [7:0] ASCII_Y = 8'h59;
	localparam int QI_SIZE = 3;
	localparam int QI_BLK_LO = 4;
	localparam int QI_BLK_HI = 5;

	// Status register layout
	localparam int STS_READY_BIT = 7;
	localparam logic [7:0] STS_ERR_MASK = 8'h3A;

	// Operation codes and error codes
	typedef enum logic [1:0] {
		OP_ERASE = 2'b00,
		OP_PROGRAM = 2'b01,
		OP_READ = 2'b10,
		OP_IDENT = 2'b11
	} pncs_op_t;

	typedef enum logic [2:0] {
		ERR_NONE = 3'b000,
		ERR_UNINIT = 3'b001,
		ERR_RANGE = 3'b010,
		ERR_ALIGN = 3'b011,
		ERR_IDENT = 3'b100,
		ERR_FLASH = 3'b101
	} pncs_err_t;

	// Completion result carried with op_done
	typedef struct packed {
		logic err;
		pncs_err_t code;
	} pncs_result_t;

	localparam pncs_result_t RESULT_RESET = '{err: 1'b0, code: ERR_NONE};

	// Sequencer states
	typedef enum logic [4:0] {
		S_IDLE = 5'h00,
		S_QCMD = 5'h01,
		S_QRD = 5'h02,
		S_IDCHK = 5'h03,
		S_RSTA = 5'h04,
		S_UNL1 = 5'h05,
		S_UNL2 = 5'h06,
		S_ERS = 5'h07,
		S_ERC = 5'h08,
		S_STC = 5'h09,
		S_STR = 5'h0A,
		S_CLR = 5'h0B,
		S_BPS = 5'h0C,
		S_BPC = 5'h0D,
		S_BPD = 5'h0E,
		S_BPF = 5'h0F,
		S_RDD = 5'h10,
		S_FIN = 5'h11
	} pncs_state_t;

	localparam pncs_state_t STATE_RESET = S_QCMD;

endpackage : pncs_pkg

// ---- design/pncs_sequencer.sv ----
// Host-side command sequencer for a CFI parallel NOR flash behind a memory controller
//
// Operation
// - Identification runs first (automatically after reset) and nothing else is served until it succeeds.
// - Identification starts with a write of the query command 0x0098 to flash address zero.
// - Query offsets 0x10, 0x11, 0x12 must read Q, R, Y or identification fails.
// - The geometry bytes are read right after Q, R, Y, before the check, and kept for bounds and block arithmetic.
// - Each erased block is unlocked, then gets 0x20 and 0xD0 at its own block address.
// - An erase of any byte count inside the device erases every block the range touches.
// - Erase completion is reported only after success or a detected error, with an error flag.
// - Program counts from zero to the full capacity are allowed and a zero count touches nothing.
// - A program whose start or end lies outside the device is refused with an error and no flash access.
// - Program source, destination and byte count must be aligned to the 16-bit flash bus or the request is refused.
// - Program runs only when initialized_flag is 1, then resets the flash to read array and unlocks.
// - Program data goes out as buffered programs and success needs the flash to report completion.
// - Read counts from zero to the full capacity are served as words starting at the offset.
// - A read whose start offset lies beyond the device is refused with an error.
// - Read resets the flash to read array and unlocks the block before fetching data.
`timescale 1ns/100ps
module pncs_sequencer
	import pncs_pkg::*;
#(
	parameter int AW = 26,
	parameter int BUF_WORDS = 32
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// Operation request and completion
	input wire logic op_valid,
	input wire pncs_op_t op_code,
	input wire logic [AW:0] op_offset,
	input wire logic [AW:0] op_src,
	input wire logic [AW+1:0] op_count,
	output logic op_ready,
	output logic op_done,
	output pncs_result_t op_result,
	output logic initialized_flag,
	// Program data stream
	input wire logic wr_valid,
	input wire logic [DATA_W-1:0] wr_data,
	output logic wr_ready,
	// Read data stream
	output logic rd_valid,
	output logic [DATA_W-1:0] rd_data,
	// Flash access through the memory controller
	output logic mem_req,
	output logic mem_we,
	output logic [AW-1:0] mem_addr,
	output logic [DATA_W-1:0] mem_wdata,
	input wire logic mem_ack,
	input wire logic [DATA_W-1:0] mem_rdata
);

	localparam int BL = $clog2(BUF_WORDS);
	localparam int CW = BL + 1;

	// Geometry and buffer size must fit the address arithmetic
	if (AW < 9 || AW > 30 || BUF_WORDS < 2 || (1 << BL) != BUF_WORDS || BL >= AW) begin : g_bad_param
		$error("pncs_sequencer: unsupported AW or BUF_WORDS");
	end

	pncs_state_t state, next_state;
	pncs_op_t op, next_op;
	pncs_result_t next_op_result;
	logic [AW+1:0] cur, next_cur;
	logic [AW+1:0] last, next_last;
	logic [AW:0] remain, next_remain;
	logic [CW-1:0] chunk, next_chunk;
	logic [2:0] qidx, next_qidx;
	logic [QRY_COUNT-1:0][7:0] qry, next_qry;
	logic closing, next_closing;
	logic next_initialized_flag, next_op_ready, next_op_done, next_wr_ready, next_rd_valid;
	logic [DATA_W-1:0] next_rd_data;
	logic next_mem_req, next_mem_we;
	logic [AW-1:0] next_mem_addr;
	logic [DATA_W-1:0] next_mem_wdata;

	// Geometry derived from the kept query bytes
	logic [AW+1:0] dev_bytes, blk_bytes, blk_mask, cur_blk, nxt_blk, req_end;
	logic [CW-1:0] room, chunk_calc;
	logic qry_ok, off_bad, end_bad, align_bad, acc, take;

	assign dev_bytes = (AW + 2)'(1) << qry[QI_SIZE];
	assign blk_bytes = (AW + 2)'({qry[QI_BLK_HI], qry[QI_BLK_LO], 8'h00});
	assign blk_mask = blk_bytes - (AW + 2)'(1);
	assign cur_blk = cur & ~blk_mask;
	assign nxt_blk = cur_blk + blk_bytes;
	assign req_end = (AW + 2)'(op_offset) + op_count;
	// Out-of-device size exponents would wrap the shift, so they fail identification
	assign qry_ok = qry[0] == ASCII_Q && qry[1] == ASCII_R && qry[2] == ASCII_Y
		&& qry[QI_SIZE] <= 8'(AW + 1) && {qry[QI_BLK_HI], qry[QI_BLK_LO]} != 16'h0000;
	assign off_bad = (AW + 2)'(op_offset) >= dev_bytes;
	assign end_bad = req_end > dev_bytes;
	assign align_bad = op_offset[0] | op_src[0] | op_count[0];
	assign acc = mem_req & mem_ack;
	assign take = wr_ready & wr_valid;
	// A chunk never crosses a write-buffer boundary of the flash
	assign room = CW'(BUF_WORDS) - CW'(cur[BL:1]);
	assign chunk_calc = ((AW + 1)'(room) > remain) ? CW'(remain) : room;

	// Address and data of the access each state performs
	logic a_go, a_we;
	logic [AW-1:0] a_addr;
	logic [DATA_W-1:0] a_data;
	always_comb begin
		a_go = 1'b1;
		a_we = 1'b1;
		a_addr = cur_blk[AW:1];
		a_data = CMD_READ_ARRAY;
		case (state)
			S_QCMD: begin
				a_addr = '0;
				a_data = CMD_QUERY;
			end
			S_QRD: begin
				a_we = 1'b0;
				a_addr = AW'(QRY_OFFS[qidx*8 +: 8]);
			end
			S_RSTA: a_data = CMD_READ_ARRAY;
			S_UNL1: a_data = CMD_UNLOCK_SETUP;
			S_UNL2: a_data = CMD_CONFIRM;
			S_ERS: a_data = CMD_ERASE_SETUP;
			S_ERC: a_data = CMD_CONFIRM;
			S_STC: a_data = CMD_READ_STATUS;
			S_STR: a_we = 1'b0;
			S_CLR: a_data = CMD_CLEAR_STATUS;
			S_BPS: a_data = CMD_BUF_PROG;
			S_BPC: a_data = DATA_W'(chunk - CW'(1));
			S_BPD: begin
				a_go = take;
				a_addr = cur[AW:1];
				a_data = wr_data;
			end
			S_BPF: a_data = CMD_CONFIRM;
			S_RDD: begin
				a_we = 1'b0;
				a_addr = cur[AW:1];
			end
			default: a_go = 1'b0;
		endcase
	end

	// Sequencer next state
	always_comb begin
		next_state = state;
		next_op = op;
		next_op_result = op_result;
		next_cur = cur;
		next_last = last;
		next_remain = remain;
		next_chunk = chunk;
		next_qidx = qidx;
		next_qry = qry;
		next_closing = closing;
		next_initialized_flag = initialized_flag;
		next_op_done = 1'b0;
		next_rd_valid = 1'b0;
		next_rd_data = rd_data;
		next_wr_ready = 1'b0;
		next_mem_req = mem_req;
		next_mem_we = mem_we;
		next_mem_addr = mem_addr;
		next_mem_wdata = mem_wdata;
		// Request holds until acknowledged, then drops for a cycle
		if (a_go && !mem_req) begin
			next_mem_req = 1'b1;
			next_mem_we = a_we;
			next_mem_addr = a_addr;
			next_mem_wdata = a_data;
		end
		if (acc) begin
			next_mem_req = 1'b0;
		end
		case (state)
			S_IDLE: begin
				if (op_valid) begin
					next_op = op_code;
					next_op_result = RESULT_RESET;
					next_cur = (AW + 2)'(op_offset);
					next_closing = 1'b0;
					next_state = S_RSTA;
					if (op_code == OP_IDENT) begin
						next_initialized_flag = 1'b0;
						next_qidx = '0;
						next_state = S_QCMD;
					end else if (!initialized_flag) begin
						next_op_result = '{err: 1'b1, code: ERR_UNINIT};
						next_state = S_FIN;
					end else begin
						case (op_code)
							OP_ERASE: begin
								next_last = req_end - (AW + 2)'(1);
								if (off_bad || end_bad) begin
									next_op_result = '{err: 1'b1, code: ERR_RANGE};
									next_state = S_FIN;
								end else if (op_count == '0) begin
									next_state = S_FIN;
								end
							end
							OP_PROGRAM: begin
								next_remain = op_count[AW+1:1];
								if (align_bad) begin
									next_op_result = '{err: 1'b1, code: ERR_ALIGN};
									next_state = S_FIN;
								end else if (off_bad || end_bad) begin
									next_op_result = '{err: 1'b1, code: ERR_RANGE};
									next_state = S_FIN;
								end else if (op_count == '0) begin
									next_state = S_FIN;
								end
							end
							default: begin
								next_remain = (AW + 1)'((op_count + (AW + 2)'(1)) >> 1);
								if (off_bad) begin
									next_op_result = '{err: 1'b1, code: ERR_RANGE};
									next_state = S_FIN;
								end else if (op_count == '0) begin
									next_state = S_FIN;
								end
							end
						endcase
					end
				end
			end
			S_QCMD: if (acc) next_state = S_QRD;
			S_QRD: begin
				if (acc) begin
					next_qry[qidx] = mem_rdata[7:0];
					next_qidx = qidx + 3'h1;
					if (qidx == 3'(QRY_COUNT - 1)) begin
						next_state = S_IDCHK;
					end
				end
			end
			S_IDCHK: begin
				// Flash always goes back to read array, pass or fail
				next_cur = '0;
				next_closing = 1'b1;
				next_state = S_RSTA;
				if (qry_ok) begin
					next_initialized_flag = 1'b1;
				end else begin
					next_op_result = '{err: 1'b1, code: ERR_IDENT};
				end
			end
			S_RSTA: if (acc) next_state = closing ? S_FIN : S_UNL1;
			S_UNL1: if (acc) next_state = S_UNL2;
			S_UNL2: begin
				if (acc) begin
					next_state = (op == OP_ERASE) ? S_ERS : (op == OP_PROGRAM) ? S_BPS : S_RDD;
				end
			end
			S_ERS: if (acc) next_state = S_ERC;
			S_ERC: if (acc) next_state = S_STC;
			S_STC: if (acc) next_state = S_STR;
			S_STR: begin
				// Status reads repeat until ready
				if (acc && mem_rdata[STS_READY_BIT]) begin
					if ((mem_rdata[7:0] & STS_ERR_MASK) != 8'h00) begin
						next_op_result = '{err: 1'b1, code: ERR_FLASH};
						next_state = S_CLR;
					end else if (op == OP_ERASE) begin
						next_cur = nxt_blk;
						next_state = S_UNL1;
						if (nxt_blk > last) begin
							next_closing = 1'b1;
							next_state = S_RSTA;
						end
					end else begin
						next_state = S_UNL1;
						if (remain == '0) begin
							next_closing = 1'b1;
							next_state = S_RSTA;
						end
					end
				end
			end
			S_CLR: begin
				if (acc) begin
					next_closing = 1'b1;
					next_state = S_RSTA;
				end
			end
			S_BPS: begin
				if (acc) begin
					next_chunk = chunk_calc;
					next_state = S_BPC;
				end
			end
			S_BPC: if (acc) next_state = S_BPD;
			S_BPD: begin
				next_wr_ready = !mem_req && !take;
				if (acc) begin
					next_cur = cur + (AW + 2)'(2);
					next_remain = remain - (AW + 1)'(1);
					next_chunk = chunk - CW'(1);
					if (chunk == CW'(1)) begin
						next_state = S_BPF;
					end
				end
			end
			S_BPF: if (acc) next_state = S_STC;
			S_RDD: begin
				if (acc) begin
					next_rd_valid = 1'b1;
					next_rd_data = mem_rdata;
					next_cur = cur + (AW + 2)'(2);
					next_remain = remain - (AW + 1)'(1);
					if (remain == (AW + 1)'(1)) begin
						next_state = S_FIN;
					end
				end
			end
			S_FIN: begin
				next_op_done = 1'b1;
				next_state = S_IDLE;
			end
			default: next_state = S_IDLE;
		endcase
		next_op_ready = next_state == S_IDLE;
	end

	// Sequencer registers
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state <= STATE_RESET;
			op <= OP_IDENT;
			op_result <= RESULT_RESET;
			cur <= '0;
			last <= '0;
			remain <= '0;
			chunk <= '0;
			qidx <= '0;
			qry <= '0;
			closing <= 1'b0;
			initialized_flag <= 1'b0;
			op_ready <= 1'b0;
			op_done <= 1'b0;
			wr_ready <= 1'b0;
			rd_valid <= 1'b0;
			rd_data <= '0;
			mem_req <= 1'b0;
			mem_we <= 1'b0;
			mem_addr <= '0;
			mem_wdata <= '0;
		end else begin
			state <= next_state;
			op <= next_op;
			op_result <= next_op_result;
			cur <= next_cur;
			last <= next_last;
			remain <= next_remain;
			chunk <= next_chunk;
			qidx <= next_qidx;
			qry <= next_qry;
			closing <= next_closing;
			initialized_flag <= next_initialized_flag;
			op_ready <= next_op_ready;
			op_done <= next_op_done;
			wr_ready <= next_wr_ready;
			rd_valid <= next_rd_valid;
			rd_data <= next_rd_data;
			mem_req <= next_mem_req;
			mem_we <= next_mem_we;
			mem_addr <= next_mem_addr;
			mem_wdata <= next_mem_wdata;
		end
	end

	// Checks on the sequencer's own behaviour
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);

	logic take_op;
	assign take_op = op_valid && op_ready;

	chk_uninit_refused: assert property (
		take_op && op_code != OP_IDENT && !initialized_flag |=> state == S_FIN && !mem_req ##1 op_done && op_result.err
	) else $error("operation served before identification");

	chk_query_command: assert property (
		$rose(mem_req) && state == S_QCMD |-> mem_we && mem_addr == '0 && mem_wdata == CMD_QUERY
	) else $error("query command not written to address zero");

	chk_ident_fail: assert property (
		state == S_IDCHK && !qry_ok |=> state == S_RSTA && closing && op_result.code == ERR_IDENT && !initialized_flag
	) else $error("query mismatch not reported");

	chk_erase_confirm: assert property (
		$rose(mem_req) && state == S_ERC |-> mem_we && mem_wdata == CMD_CONFIRM && mem_addr == cur_blk[AW:1]
	) else $error("erase confirm missing or misplaced");

	chk_zero_program: assert property (
		take_op && op_code == OP_PROGRAM && initialized_flag && !align_bad && !off_bad && !end_bad && op_count == '0
		|=> !mem_req ##1 op_done && !op_result.err
	) else $error("zero program not completed cleanly");

	chk_program_range: assert property (
		take_op && op_code == OP_PROGRAM && initialized_flag && !align_bad && (off_bad || end_bad)
		|=> !mem_req ##1 op_done && op_result.code == ERR_RANGE
	) else $error("out of range program not refused");

	chk_program_align: assert property (
		take_op && op_code == OP_PROGRAM && initialized_flag && align_bad
		|=> !mem_req ##1 op_done && op_result.code == ERR_ALIGN
	) else $error("misaligned program not refused");

	chk_reset_first: assert property (
		take_op && op_code != OP_IDENT && initialized_flag && next_state == S_RSTA
		|=> state == S_RSTA ##1 mem_req && mem_we && mem_wdata == CMD_READ_ARRAY
	) else $error("array reset not issued first");

	chk_read_range: assert property (
		take_op && op_code == OP_READ && initialized_flag && off_bad
		|=> !mem_req ##1 op_done && op_result.code == ERR_RANGE
	) else $error("out of range read not refused");

	chk_status_poll: assert property (
		state == S_STR && acc && !mem_rdata[STS_READY_BIT] |=> state == S_STR ##1 mem_req && !mem_we
	) else $error("status poll stopped before ready");

	cov_ident_ok: cover property (state == S_IDCHK && qry_ok);
	cov_erase_done: cover property (op_done && op == OP_ERASE && !op_result.err);
	cov_program_done: cover property (op_done && op == OP_PROGRAM && !op_result.err);
	cov_read_done: cover property (op_done && op == OP_READ && !op_result.err);

endmodule : pncs_sequencer

// ---- test/pncs_flash_model.sv ----
// Behavioural CFI parallel NOR flash on the memory controller port
`timescale 1ns/100ps
module pncs_flash_model
	import pncs_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// Memory port
	input wire logic mem_req,
	input wire logic mem_we,
	input wire logic [25:0] mem_addr,
	input wire logic [15:0] mem_wdata,
	output logic mem_ack,
	output logic [15:0] mem_rdata,
	// Test controls: slow answers, status error, bad query
	input wire logic slow,
	input wire logic err_inj,
	input wire logic qry_bad
);
	logic [15:0] mem [0:2047];
	logic [7:0] lck, sts, q;
	logic [1:0] mode;
	logic [2:0] pend;
	logic [2:0] eb;
	int dly, busy, bpn;
	wire [10:0] a = mem_addr[10:0];
	wire [2:0] b = mem_addr[10:8];
	// Known pattern so erase and program show in readback
	initial for (int i = 0; i < 2048; i++) mem[i] = 16'h5A00 ^ 16'(i);
	// Query table of a 4 KiB device with 512-byte blocks
	always_comb begin
		case (a[7:0])
			8'h10: q = qry_bad ? 8'h00 : ASCII_Q;
			8'h11: q = ASCII_R;
			8'h12: q = ASCII_Y;
			8'h27: q = 8'h0C;
			8'h2F: q = 8'h02;
			default: q = 8'h00;
		endcase
	end
	// Locked blocks fail erase and program; released data is inverted, never held
	always @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			mem_ack <= 1'b0;
			mem_rdata <= 16'h0000;
			lck <= 8'hFF;
			sts <= 8'h00;
			mode <= 2'h0;
			pend <= 3'h0;
			dly <= 0;
			busy <= 0;
		end else if (mem_ack) begin
			mem_ack <= 1'b0;
			mem_rdata <= ~mem_rdata;
		end else if (mem_req && dly < (slow ? 3 : 0)) begin
			dly <= dly + 1;
		end else if (mem_req) begin
			dly <= 0;
			mem_ack <= 1'b1;
			if (!mem_we) begin
				busy <= (mode == 2'h2 && busy > 0) ? busy - 1 : busy;
				mem_rdata <= mode == 2'h0 ? mem[a] : mode == 2'h1 ? {8'h00, q} : {8'h00, busy == 0, sts[6:0]};
			end else case (pend)
				3'h1: begin
					if (mem_wdata == CMD_CONFIRM) lck[b] <= 1'b0;
					pend <= 3'h0;
				end
				3'h2: begin
					if (mem_wdata != CMD_CONFIRM || b != eb || lck[b] || err_inj) sts[5] <= 1'b1;
					else for (int i = 0; i < 256; i++) mem[{b, 8'(i)}] <= 16'hFFFF;
					busy <= 3;
					pend <= 3'h0;
				end
				3'h3: begin
					bpn <= mem_wdata + 1;
					pend <= 3'h4;
				end
				3'h4: begin
					if (lck[b]) sts[4] <= 1'b1;
					mem[a] <= mem[a] & mem_wdata;
					bpn <= bpn - 1;
					if (bpn == 1) pend <= 3'h5;
				end
				3'h5: begin
					if (mem_wdata != CMD_CONFIRM) sts[4] <= 1'b1;
					busy <= 3;
					pend <= 3'h0;
				end
				default: begin
					// Setup and confirm must hit one block, else the erase fails
					eb <= b;
					if (mem_wdata == CMD_READ_ARRAY) mode <= 2'h0;
					if (mem_wdata == CMD_QUERY) mode <= 2'h1;
					if (mem_wdata inside {CMD_READ_STATUS, CMD_ERASE_SETUP, CMD_BUF_PROG}) mode <= 2'h2;
					if (mem_wdata == CMD_CLEAR_STATUS) sts <= 8'h00;
					if (mem_wdata == CMD_UNLOCK_SETUP) pend <= 3'h1;
					if (mem_wdata == CMD_ERASE_SETUP) pend <= 3'h2;
					if (mem_wdata == CMD_BUF_PROG) pend <= 3'h3;
				end
			endcase
		end
	end
endmodule : pncs_flash_model

// ---- test/testbench.sv ----
// Self-checking bench for the parallel NOR flash command sequencer
`timescale 1ns/100ps
module testbench
	import pncs_pkg::*;
;
	logic sys_clk = 1'b0, sys_rst = 1'b1, op_valid = 1'b0, wr_valid = 1'b0;
	logic slow = 1'b0, err_inj = 1'b0, qry_bad = 1'b0;
	pncs_op_t op_code = OP_READ;
	logic [26:0] op_offset = 27'h0, op_src = 27'h0;
	logic [27:0] op_count = 28'h0;
	logic [15:0] wr_data = 16'h1234;
	logic op_ready, op_done, initialized_flag, wr_ready, rd_valid, mem_req, mem_we, mem_ack;
	pncs_result_t op_result;
	logic [15:0] rd_data, mem_wdata, mem_rdata;
	logic [25:0] mem_addr;
	int n_errors = 0, total_checks = 0, n_acc = 0, wr_idx = 0, cyc;
	logic [15:0] rd_q[$];
	logic [15:0] pdata[4] = '{16'h1234, 16'hABCD, 16'h0F0F, 16'h8001};
	// 10 MHz clock
	always #50 sys_clk = ~sys_clk;
	// Sequencer and far-side flash
	pncs_sequencer #(.AW(26), .BUF_WORDS(32)) dut_u (.sys_clk, .sys_rst, .op_valid, .op_code, .op_offset,
		.op_src, .op_count, .op_ready, .op_done, .op_result, .initialized_flag, .wr_valid, .wr_data,
		.wr_ready, .rd_valid, .rd_data, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_ack, .mem_rdata);
	pncs_flash_model flash_u (.sys_clk, .sys_rst, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_ack,
		.mem_rdata, .slow, .err_inj, .qry_bad);
	// Access count, read words, program data source
	always @(posedge sys_clk) begin
		if (mem_ack) n_acc <= n_acc + 1;
		if (rd_valid) rd_q.push_back(rd_data);
		if (wr_valid && wr_ready) begin
			wr_idx <= wr_idx + 1;
			wr_data <= pdata[(wr_idx + 1) % 4];
		end
	end
	task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_val
	task automatic chk_res(input pncs_result_t got, input pncs_result_t exp);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_res
	task automatic stop_test;
		$display("checks=%0d errors=%0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : stop_test
	// Bounded wait for the completion pulse; a hang ends the run
	task automatic wait_done(input int lim);
		cyc = 0;
		do begin
			@(posedge sys_clk);
			cyc++;
		end while (op_done !== 1'b1 && cyc < lim);
		if (op_done !== 1'b1) begin
			n_errors++;
			stop_test;
		end
	endtask : wait_done
	// One request; refused ones must finish in two cycles with no flash access
	task automatic op_chk(input pncs_op_t c, input logic [26:0] off, input logic [26:0] src,
		input logic [27:0] cnt, input pncs_err_t code, input logic refused);
		int a0;
		a0 = n_acc;
		op_code <= c;
		op_offset <= off;
		op_src <= src;
		op_count <= cnt;
		op_valid <= 1'b1;
		@(posedge sys_clk);
		chk_val(op_ready, 1);
		op_valid <= 1'b0;
		wait_done(20000);
		chk_res(op_result, pncs_result_t'{code != ERR_NONE, code});
		if (refused) begin
			chk_val(cyc, 2);
			chk_val(n_acc - a0, 0);
		end
	endtask : op_chk
	task automatic rd_chk(input logic [26:0] off, input logic [27:0] cnt, input logic [15:0] exp[$]);
		rd_q.delete();
		op_chk(OP_READ, off, 27'h0, cnt, ERR_NONE, 1'b0);
		chk_val(rd_q.size(), exp.size());
		foreach (exp[i]) chk_val(rd_q[i], exp[i]);
	endtask : rd_chk
	task automatic t_refuse;
		op_chk(OP_PROGRAM, 27'h200, 27'h1, 28'h4, ERR_ALIGN, 1'b1);
		op_chk(OP_PROGRAM, 27'h201, 27'h0, 28'h4, ERR_ALIGN, 1'b1);
		op_chk(OP_PROGRAM, 27'hFFE, 27'h0, 28'h4, ERR_RANGE, 1'b1);
		op_chk(OP_PROGRAM, 27'h1000, 27'h0, 28'h2, ERR_RANGE, 1'b1);
		op_chk(OP_READ, 27'h1000, 27'h0, 28'h2, ERR_RANGE, 1'b1);
		op_chk(OP_ERASE, 27'h1000, 27'h0, 28'h2, ERR_RANGE, 1'b1);
		op_chk(OP_PROGRAM, 27'h200, 27'h0, 28'h0, ERR_NONE, 1'b1);
		op_chk(OP_READ, 27'h0, 27'h0, 28'h0, ERR_NONE, 1'b1);
	endtask : t_refuse
	// Range straddling a block boundary erases both blocks and nothing more
	task automatic t_erase;
		op_chk(OP_ERASE, 27'h1FE, 27'h0, 28'h4, ERR_NONE, 1'b0);
		rd_chk(27'h0, 28'h2, '{16'hFFFF});
		rd_chk(27'h3FE, 28'h4, '{16'hFFFF, 16'h5A00 ^ 16'h0200});
	endtask : t_erase
	// Buffered program with a slow flash, then readback of an odd byte count
	task automatic t_prog;
		slow <= 1'b1;
		wr_valid <= 1'b1;
		op_chk(OP_PROGRAM, 27'h200, 27'h100, 28'h8, ERR_NONE, 1'b0);
		chk_val(wr_idx, 4);
		// Start two words below a write-buffer boundary, so two chunks go out
		op_chk(OP_PROGRAM, 27'h23C, 27'h100, 28'h8, ERR_NONE, 1'b0);
		chk_val(wr_idx, 8);
		wr_valid <= 1'b0;
		slow <= 1'b0;
		rd_chk(27'h200, 28'h7, '{16'h1234, 16'hABCD, 16'h0F0F, 16'h8001});
		rd_chk(27'h23C, 28'h8, '{16'h1234, 16'hABCD, 16'h0F0F, 16'h8001});
		rd_chk(27'h208, 28'h4, '{16'hFFFF, 16'hFFFF});
	endtask : t_prog
	// Status error fails the erase; the next erase must see cleared status
	task automatic t_ferr;
		err_inj <= 1'b1;
		op_chk(OP_ERASE, 27'h800, 27'h0, 28'h2, ERR_FLASH, 1'b0);
		err_inj <= 1'b0;
		op_chk(OP_ERASE, 27'h800, 27'h0, 28'h2, ERR_NONE, 1'b0);
	endtask : t_ferr
	// Failed identification blocks every other operation
	task automatic t_badq;
		pncs_op_t ops[3] = '{OP_ERASE, OP_PROGRAM, OP_READ};
		qry_bad <= 1'b1;
		op_chk(OP_IDENT, 27'h0, 27'h0, 28'h0, ERR_IDENT, 1'b0);
		chk_val(initialized_flag, 0);
		foreach (ops[i]) op_chk(ops[i], 27'h200, 27'h0, 28'h2, ERR_UNINIT, 1'b1);
		qry_bad <= 1'b0;
		op_chk(OP_IDENT, 27'h0, 27'h0, 28'h0, ERR_NONE, 1'b0);
		chk_val(initialized_flag, 1);
	endtask : t_badq
	// Reset in the middle of an erase; identification must run again
	task automatic t_reset;
		op_code <= OP_ERASE;
		op_offset <= 27'h400;
		op_count <= 28'h2;
		op_valid <= 1'b1;
		@(posedge sys_clk);
		op_valid <= 1'b0;
		repeat (4) @(posedge sys_clk);
		sys_rst <= 1'b1;
		repeat (2) @(posedge sys_clk);
		chk_val({op_ready, op_done, rd_valid, wr_ready, mem_req, initialized_flag}, 0);
		sys_rst <= 1'b0;
		repeat (2) @(posedge sys_clk);
		chk_val(op_ready, 0);
		wait_done(1000);
		chk_res(op_result, RESULT_RESET);
		chk_val(initialized_flag, 1);
	endtask : t_reset
	// Reset, automatic identification, then the scenarios
	initial begin
		repeat (5) @(posedge sys_clk);
		sys_rst <= 1'b0;
		repeat (2) @(posedge sys_clk);
		chk_val(op_ready, 0);
		wait_done(1000);
		chk_res(op_result, RESULT_RESET);
		chk_val(initialized_flag, 1);
		t_refuse;
		t_erase;
		t_prog;
		t_ferr;
		t_badq;
		t_reset;
		stop_test;
	end
endmodule : testbench
